// file: src/ppg_cfg.svh
`ifndef PPG_CFG_SVH
`define PPG_CFG_SVH
// Notes on behaviour
// - Counter mode steps a 4-bit count at rate f; pins toggle f/2..f/16.
// - Counter direction is selectable, up or down.
// - Arbitrary and test signals start by continuous or one-shot manual trigger.
// - Pattern length sets how many samples are played per pass.
// - Clear erases the pattern, length back to 1, sample value 0.
// - Every sample is held for the same bit time.
// - One pass lasts pattern length times bit time.
// - With burst enabled, outputs pause for idle time after each pass.
// - Idle time is 20 ns to 42 s in 10 ns steps.
// - Repeat count sets how many passes are played per trigger.
// - Manual mode drives each pin from its own static level bit.
// - Serial modes send fixed pseudo-random traffic; only protocol, rate and UART polarity selectable.
// - Serial pin map: UART, SPI, I2C, CAN, LIN on fixed pins; SPI uses all four, the others leave pins 2, 3 unused.
// - UART rates are 9600, 115200 and 1000000 bit/s.
// - SPI rates are 100k, 250k and 1M bit/s.
// - I2C rates are 100k, 400k, 1000k and 3400k bit/s.
// - CAN rates 50k, 100k, 1M; LIN rates 9.6k, 10.417k, 19.2k bit/s.
// - UART polarity setting selects the active level of both UART lines.
// - PWM mode drives pin 0 with programmable period and duty.
// - PWM mode also drives motor direction and motor enable levels.
// - LED mode drives red, green, blue PWM plus intensity PWM on pin 3.
// - Test mode: ramp PWM pin 0, sine PWM pin 1, sync pulses pins 2, 3.
// - A global enable gates all four outputs.
// - Counter and arbitrary words are 4 bits, one bit per pin.

// ----------------------------------------
// Clock and tick
// ----------------------------------------
`define PPG_CLK_HZ      100000000
`define PPG_CLK_NS      10
`define PPG_TICK_NS     10
`define PPG_TICK_CYC    ((`PPG_TICK_NS + `PPG_CLK_NS - 1) / `PPG_CLK_NS)
`define PPG_IDLE_MIN_NS 20
`define PPG_IDLE_MIN    (`PPG_IDLE_MIN_NS / `PPG_TICK_NS)
`define PPG_LEN_RST     1

// ----------------------------------------
// Serial frame and rates in bit/s
// ----------------------------------------
`define PPG_DATA_LAST   8
`define PPG_FRAME_LAST  10
`define PPG_LFSR_SEED   8'ha5
`define PPG_LFSR_TAPS   8'hb8
`define PPG_UART_R0     9600
`define PPG_UART_R1     115200
`define PPG_UART_R2     1000000
`define PPG_SPI_R0      100000
`define PPG_SPI_R1      250000
`define PPG_SPI_R2      1000000
`define PPG_I2C_R0      100000
`define PPG_I2C_R1      400000
`define PPG_I2C_R2      1000000
`define PPG_I2C_R3      3400000
`define PPG_CAN_R0      50000
`define PPG_CAN_R1      100000
`define PPG_CAN_R2      1000000
`define PPG_LIN_R0      9600
`define PPG_LIN_R1      10417
`define PPG_LIN_R2      19200
`endif

// file: src/ppg_pkg.sv
package ppg_pkg;
    typedef enum logic [3:0] {
        PPG_CNT, PPG_ARB, PPG_MAN, PPG_UART, PPG_SPI, PPG_I2C,
        PPG_CAN, PPG_LIN, PPG_PWM, PPG_LED, PPG_TEST
    } ppg_mode_t;
    typedef enum logic [1:0] {ARB_IDLE, ARB_PLAY, ARB_GAP} ppg_arb_st_t;
endpackage

// file: src/ppg_pwm.sv
`timescale 1ns/1ps
module ppg_pwm #(
    parameter int unsigned N = 4,
    parameter int unsigned W = 32
) (
    // Clock and reset
    input  wire logic                i_clk,
    input  wire logic                i_rst_b,
    // Timing
    input  wire logic                i_tick,
    input  wire logic [W-1:0]        i_period,
    input  wire logic [N-1:0][W-1:0] i_duty,
    // Waveforms
    output logic      [N-1:0]        o_pwm,
    output logic                     o_wrap
);
    logic [W-1:0] cnt_r;
    logic [W-1:0] last;

    assign last = (i_period == '0) ? '0 : i_period - 1'b1;

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            cnt_r  <= '0;
            o_wrap <= 1'b0;
        end else begin
            o_wrap <= 1'b0;
            if (i_tick) begin
                if (cnt_r >= last) begin
                    cnt_r  <= '0;
                    o_wrap <= 1'b1;
                end else begin
                    cnt_r <= cnt_r + 1'b1;
                end
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_pwm <= '0;
        end else begin
            for (int k = 0; k < N; k++) begin
                o_pwm[k] <= (cnt_r < i_duty[k]);
            end
        end
    end

    AST_PWM_ZERO: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (i_duty[0] == '0) ##1 (i_duty[0] == '0) |-> !o_pwm[0])
        else $error("pwm high with zero duty");
endmodule

// file: src/ppg_top.sv
`timescale 1ns/1ps
`include "ppg_cfg.svh"
module ppg_top import ppg_pkg::*; #(
    parameter int unsigned DEPTH    = 16,
    parameter int unsigned W        = 32,
    parameter int unsigned DIV_U0   = `PPG_CLK_HZ / `PPG_UART_R0,
    parameter int unsigned DIV_L0   = `PPG_CLK_HZ / `PPG_LIN_R0,
    parameter int unsigned DIV_L1   = `PPG_CLK_HZ / `PPG_LIN_R1,
    parameter int unsigned DIV_L2   = `PPG_CLK_HZ / `PPG_LIN_R2,
    parameter int unsigned IW       = $clog2(DEPTH)
) (
    // Clock and reset
    input  wire logic          i_clk,
    input  wire logic          i_rst_b,
    // Global
    input  wire ppg_mode_t     i_mode,
    input  wire logic          i_out_en,
    // Counter
    input  wire logic [W-1:0]  i_cnt_div,
    input  wire logic          i_cnt_down,
    // Trigger and timing
    input  wire logic          i_trig_cont,
    input  wire logic          i_trig_single,
    input  wire logic [W-1:0]  i_bit_time,
    input  wire logic          i_burst_en,
    input  wire logic [W-1:0]  i_idle_time,
    input  wire logic [W-1:0]  i_ncycle,
    // Pattern memory
    input  wire logic          i_pat_clear,
    input  wire logic          i_len_wr,
    input  wire logic [IW:0]   i_len_val,
    input  wire logic          i_smp_wr,
    input  wire logic [IW-1:0] i_smp_idx,
    input  wire logic [3:0]    i_smp_val,
    // Manual and serial
    input  wire logic [3:0]    i_manual,
    input  wire logic [1:0]    i_bus_rate,
    input  wire logic          i_uart_pol,
    // PWM
    input  wire logic [W-1:0]  i_pwm_period,
    input  wire logic [W-1:0]  i_pwm_duty,
    input  wire logic          i_motor_dir,
    input  wire logic          i_motor_en,
    input  wire logic [W-1:0]  i_led_red,
    input  wire logic [W-1:0]  i_led_green,
    input  wire logic [W-1:0]  i_led_blue,
    input  wire logic [W-1:0]  i_led_intens,
    // Pins and status
    output logic               o_pattern_out_0,
    output logic               o_pattern_out_1,
    output logic               o_pattern_out_2,
    output logic               o_pattern_out_3,
    output logic [IW:0]        o_pat_len,
    output logic [IW-1:0]      o_pat_idx,
    output logic               o_arb_busy
);
    localparam logic [7:0]   TICK_LAST = 8'(`PPG_TICK_CYC - 1);
    localparam logic [W-1:0] IDLE_MIN  = W'(`PPG_IDLE_MIN);
    localparam logic [IW:0]  LEN_RST   = (IW+1)'(`PPG_LEN_RST);
    localparam logic [IW:0]  LEN_MAX   = (IW+1)'(DEPTH);
    localparam logic [3:0]   D_LAST    = 4'(`PPG_DATA_LAST);
    localparam logic [3:0]   F_LAST    = 4'(`PPG_FRAME_LAST);

    function automatic logic [W-1:0] max1(input logic [W-1:0] x);
        return (x == '0) ? W'(1) : x;
    endfunction

    // ----------------------------------------
    // Bit period per protocol and rate select
    // ----------------------------------------
    function automatic logic [W-1:0] rate_div(input ppg_mode_t m,
                                              input logic [1:0] s);
        logic [W-1:0] d;
        d = W'(`PPG_CLK_HZ / `PPG_UART_R2);
        case (m)
            PPG_UART: d = (s == 2'd0) ? W'(DIV_U0) :
                          (s == 2'd1) ? W'(`PPG_CLK_HZ / `PPG_UART_R1) :
                                        W'(`PPG_CLK_HZ / `PPG_UART_R2);
            PPG_SPI:  d = (s == 2'd0) ? W'(`PPG_CLK_HZ / `PPG_SPI_R0) :
                          (s == 2'd1) ? W'(`PPG_CLK_HZ / `PPG_SPI_R1) :
                                        W'(`PPG_CLK_HZ / `PPG_SPI_R2);
            PPG_I2C:  d = (s == 2'd0) ? W'(`PPG_CLK_HZ / `PPG_I2C_R0) :
                          (s == 2'd1) ? W'(`PPG_CLK_HZ / `PPG_I2C_R1) :
                          (s == 2'd2) ? W'(`PPG_CLK_HZ / `PPG_I2C_R2) :
                                        W'(`PPG_CLK_HZ / `PPG_I2C_R3);
            PPG_CAN:  d = (s == 2'd0) ? W'(`PPG_CLK_HZ / `PPG_CAN_R0) :
                          (s == 2'd1) ? W'(`PPG_CLK_HZ / `PPG_CAN_R1) :
                                        W'(`PPG_CLK_HZ / `PPG_CAN_R2);
            PPG_LIN:  d = (s == 2'd0) ? W'(DIV_L0) :
                          (s == 2'd1) ? W'(DIV_L1) : W'(DIV_L2);
            default:  d = W'(`PPG_CLK_HZ / `PPG_UART_R2);
        endcase
        return d;
    endfunction

    function automatic logic [W-1:0] scale16(input logic [W-1:0] p,
                                             input logic [4:0] k);
        return W'((p >> 4) * k);
    endfunction

    function automatic logic [4:0] sine16(input logic [3:0] ph);
        logic [4:0] v;
        case (ph)
            4'h0, 4'h8: v = 5'h08;
            4'h1, 4'h7: v = 5'h0b;
            4'h2, 4'h6: v = 5'h0e;
            4'h3, 4'h5: v = 5'h0f;
            4'h4:       v = 5'h10;
            4'h9, 4'hf: v = 5'h05;
            4'ha, 4'he: v = 5'h02;
            4'hb, 4'hd: v = 5'h01;
            default:    v = 5'h00;
        endcase
        return v;
    endfunction

    logic              tick;
    logic [7:0]        tick_cnt_r;
    logic [3:0]        cnt_r;
    logic [W-1:0]      cdiv_r;
    logic [3:0]        mem_r [DEPTH];
    logic [IW:0]       len_r;
    logic [IW-1:0]     idx_r;
    logic [W-1:0]      bit_r;
    logic [W-1:0]      idle_r;
    logic [W-1:0]      pass_r;
    ppg_arb_st_t       st_r;
    logic              start;
    logic              samp_end;
    logic              pass_end;
    logic              last_pass;
    logic [W-1:0]      idle_last;
    logic [W-1:0]      s_cnt_r;
    logic [W-1:0]      s_half;
    logic              s_ph_r;
    logic [3:0]        s_bit_r;
    logic [7:0]        s_byte_r;
    logic [7:0]        lfsr_r;
    logic              s_val;
    logic              s_act;
    logic [3:0]        ph_r;
    logic              sync_r;
    logic [3:0]        pwm;
    logic              wrap;
    logic [3:0][W-1:0] duty;
    logic [3:0]        out_nxt;

    // ----------------------------------------
    // Tick and counter mode
    // ----------------------------------------
    assign tick = (tick_cnt_r == TICK_LAST);

    always_ff @(posedge i_clk) begin
        if (!i_rst_b || tick) begin
            tick_cnt_r <= '0;
        end else begin
            tick_cnt_r <= tick_cnt_r + 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b || i_mode != PPG_CNT) begin
            cdiv_r <= '0;
            cnt_r  <= '0;
        end else if (tick) begin
            if (cdiv_r >= max1(i_cnt_div) - 1'b1) begin
                cdiv_r <= '0;
                cnt_r  <= i_cnt_down ? cnt_r - 1'b1 : cnt_r + 1'b1;
            end else begin
                cdiv_r <= cdiv_r + 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Pattern store
    // ----------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_rst_b || i_pat_clear) begin
            len_r <= LEN_RST;
            for (int k = 0; k < DEPTH; k++) begin
                mem_r[k] <= '0;
            end
        end else begin
            if (i_len_wr) begin
                len_r <= (i_len_val == '0) ? LEN_RST :
                         (i_len_val > LEN_MAX) ? LEN_MAX : i_len_val;
            end
            if (i_smp_wr) begin
                mem_r[i_smp_idx] <= i_smp_val;
            end
        end
    end

    // ----------------------------------------
    // Pattern player
    // ----------------------------------------
    // Length is sampled live; change it only while idle.
    assign start     = (i_trig_cont || i_trig_single) &&
                       (i_mode == PPG_ARB || i_mode == PPG_TEST);
    assign samp_end  = tick && bit_r >= max1(i_bit_time) - 1'b1;
    assign pass_end  = samp_end && ({1'b0, idx_r} >= len_r - 1'b1);
    assign last_pass = (pass_r >= max1(i_ncycle) - 1'b1);
    assign idle_last = ((i_idle_time < IDLE_MIN) ? IDLE_MIN : i_idle_time)
                       - 1'b1;

    always_ff @(posedge i_clk) begin
        if (!i_rst_b || i_pat_clear) begin
            st_r   <= ARB_IDLE;
            idx_r  <= '0;
            bit_r  <= '0;
            idle_r <= '0;
            pass_r <= '0;
        end else begin
            case (st_r)
                ARB_IDLE: begin
                    if (start) begin
                        st_r   <= ARB_PLAY;
                        idx_r  <= '0;
                        bit_r  <= '0;
                        pass_r <= '0;
                    end
                end
                ARB_PLAY: begin
                    if (tick) begin
                        bit_r <= samp_end ? '0 : bit_r + 1'b1;
                    end
                    if (pass_end) begin
                        idx_r <= '0;
                        if (i_burst_en) begin
                            st_r   <= ARB_GAP;
                            idle_r <= '0;
                        end else if (last_pass) begin
                            st_r <= ARB_IDLE;
                        end else begin
                            pass_r <= pass_r + 1'b1;
                        end
                    end else if (samp_end) begin
                        idx_r <= idx_r + 1'b1;
                    end
                end
                ARB_GAP: begin
                    if (tick) begin
                        if (idle_r >= idle_last) begin
                            st_r   <= last_pass ? ARB_IDLE : ARB_PLAY;
                            pass_r <= pass_r + 1'b1;
                            bit_r  <= '0;
                        end else begin
                            idle_r <= idle_r + 1'b1;
                        end
                    end
                end
                default: st_r <= ARB_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // Serial stimulus engine
    // ----------------------------------------
    // Content is fixed: one LFSR byte per frame, start and stop framed.
    assign s_half = max1(rate_div(i_mode, i_bus_rate) >> 1);

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            s_cnt_r  <= '0;
            s_ph_r   <= 1'b0;
            s_bit_r  <= '0;
            s_byte_r <= `PPG_LFSR_SEED;
        end else if (tick) begin
            if (s_cnt_r >= s_half - 1'b1) begin
                s_cnt_r <= '0;
                s_ph_r  <= ~s_ph_r;
                if (s_ph_r) begin
                    s_bit_r <= (s_bit_r == F_LAST) ? '0 : s_bit_r + 1'b1;
                    if (s_bit_r == F_LAST) begin
                        s_byte_r <= lfsr_r;
                    end
                end
            end else begin
                s_cnt_r <= s_cnt_r + 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            lfsr_r <= `PPG_LFSR_SEED;
        end else if (tick && s_ph_r && s_bit_r == F_LAST &&
                     s_cnt_r >= s_half - 1'b1) begin
            lfsr_r <= {lfsr_r[6:0], ^(lfsr_r & `PPG_LFSR_TAPS)};
        end
    end

    assign s_act = (s_bit_r <= D_LAST);
    assign s_val = (s_bit_r == '0) ? 1'b0 :
                   s_act ? s_byte_r[3'(s_bit_r - 1'b1)] : 1'b1;

    // ----------------------------------------
    // PWM family
    // ----------------------------------------
    always_comb begin
        duty = '0;
        case (i_mode)
            PPG_PWM:  duty[0] = i_pwm_duty;
            PPG_LED:  duty = {i_led_intens, i_led_blue,
                              i_led_green, i_led_red};
            PPG_TEST: begin
                duty[0] = scale16(i_pwm_period, {1'b0, ph_r});
                duty[1] = scale16(i_pwm_period, sine16(ph_r));
            end
            default:  duty = '0;
        endcase
    end

    ppg_pwm #(.N(4), .W(W)) u_pwm (
        .i_clk    (i_clk),
        .i_rst_b  (i_rst_b),
        .i_tick   (tick),
        .i_period (i_pwm_period),
        .i_duty   (duty),
        .o_pwm    (pwm),
        .o_wrap   (wrap)
    );

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            ph_r   <= '0;
            sync_r <= 1'b0;
        end else begin
            sync_r <= wrap;
            if (wrap) begin
                ph_r <= ph_r + 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Output select and gating
    // ----------------------------------------
    always_comb begin
        case (i_mode)
            PPG_CNT:  out_nxt = cnt_r;
            PPG_ARB:  out_nxt = (st_r == ARB_PLAY) ? mem_r[idx_r] : '0;
            PPG_MAN:  out_nxt = i_manual;
            PPG_UART: out_nxt = {2'b00, ~i_uart_pol,
                                 s_val ^ i_uart_pol};
            PPG_SPI:  out_nxt = {~s_act, ~s_val & s_act,
                                 s_val & s_act, s_ph_r & s_act};
            PPG_I2C:  out_nxt = {2'b00, s_val, s_act ? s_ph_r : 1'b1};
            PPG_CAN:  out_nxt = {2'b00, s_val, ~s_val};
            PPG_LIN:  out_nxt = {2'b00, ~s_val, s_val};
            PPG_PWM:  out_nxt = {1'b0, i_motor_en,
                                 i_motor_dir, pwm[0]};
            PPG_LED:  out_nxt = pwm;
            PPG_TEST: out_nxt = (st_r == ARB_PLAY) ?
                                {ph_r == '0, sync_r, pwm[1:0]} : '0;
            default:  out_nxt = '0;
        endcase
        if (!i_out_en || st_r == ARB_GAP) begin
            out_nxt = '0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            {o_pattern_out_3, o_pattern_out_2,
             o_pattern_out_1, o_pattern_out_0} <= '0;
            o_arb_busy <= 1'b0;
        end else begin
            {o_pattern_out_3, o_pattern_out_2,
             o_pattern_out_1, o_pattern_out_0} <= out_nxt;
            o_arb_busy <= (st_r != ARB_IDLE);
        end
    end

    assign o_pat_len = len_r;
    assign o_pat_idx = idx_r;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);

    AST_CNT_UP: assert property (
        (i_mode == PPG_CNT && tick && !i_cnt_down && $stable(i_mode) &&
         cdiv_r >= max1(i_cnt_div) - 1'b1) |=> cnt_r == $past(cnt_r) + 4'h1)
        else $error("counter did not step up");
    AST_CNT_DN: assert property (
        (i_mode == PPG_CNT && tick && i_cnt_down && $stable(i_mode) &&
         cdiv_r >= max1(i_cnt_div) - 1'b1) |=> cnt_r == $past(cnt_r) - 4'h1)
        else $error("counter did not step down");
    AST_CLEAR: assert property (
        i_pat_clear |=> len_r == LEN_RST && mem_r[0] == '0 &&
                        st_r == ARB_IDLE)
        else $error("clear did not reset pattern");
    AST_MANUAL: assert property (
        (i_mode == PPG_MAN && i_out_en) |=>
        {o_pattern_out_3, o_pattern_out_2, o_pattern_out_1,
         o_pattern_out_0} == $past(i_manual))
        else $error("manual levels not driven");
    AST_DISABLED: assert property (
        !i_out_en |=> !o_pattern_out_0 && !o_pattern_out_1 &&
                      !o_pattern_out_2 && !o_pattern_out_3)
        else $error("output active while disabled");
    AST_GAP_LOW: assert property (
        st_r == ARB_GAP |=> {o_pattern_out_3, o_pattern_out_2,
                             o_pattern_out_1, o_pattern_out_0} == '0)
        else $error("output active during idle");
    AST_HOLD: assert property (
        (st_r == ARB_PLAY && !samp_end && !i_pat_clear) |=> $stable(idx_r))
        else $error("sample changed before bit time");
    AST_PASS_WRAP: assert property (
        (st_r == ARB_PLAY && pass_end && !i_pat_clear) |=> idx_r == '0)
        else $error("pass did not restart at sample zero");
    AST_BURST: assert property (
        (st_r == ARB_PLAY && pass_end && i_burst_en && !i_pat_clear)
        |=> st_r == ARB_GAP ##1 st_r == ARB_GAP)
        else $error("burst idle shorter than two ticks");
    AST_UART_IDLE: assert property (
        (i_mode == PPG_UART && i_out_en && s_bit_r == F_LAST)
        |=> o_pattern_out_0 == !$past(i_uart_pol))
        else $error("uart idle level wrong");
endmodule

// file: tb/ppg_bench.sv
`timescale 1ns/1ps
module ppg_bench import ppg_pkg::*;;
    // ----------------------------------------
    // Stimulus and pins
    // ----------------------------------------
    logic i_clk = 1'b0, i_rst_b = 1'b0, out_en = 1'b0, down = 1'b0;
    logic t_one = 1'b0, burst = 1'b0, clr = 1'b0, len_wr = 1'b0, cont = 1'b0;
    logic smp_wr = 1'b0, busy, p0, p1, p2, p3;
    ppg_mode_t mode = PPG_MAN;
    logic [31:0] div = 32'h2, bt = 32'h2, idle = 32'h3, ncyc = 32'h1;
    logic [4:0] len = 5'h1, plen;
    logic [3:0] idx = 4'h0, sval = 4'h0, man = 4'h0, word, n0, pidx;
    logic [7:0] rises, r0;
    int fail_count = 0, checked = 0;
    always #5 i_clk = ~i_clk;

    ppg_top #(.DIV_U0(8), .DIV_L0(8), .DIV_L1(8), .DIV_L2(8)) i_ppg_top (
        .i_clk(i_clk), .i_rst_b(i_rst_b), .i_mode(mode), .i_out_en(out_en),
        .i_cnt_div(div), .i_cnt_down(down), .i_trig_cont(cont),
        .i_trig_single(t_one), .i_bit_time(bt), .i_burst_en(burst),
        .i_idle_time(idle), .i_ncycle(ncyc), .i_pat_clear(clr),
        .i_len_wr(len_wr), .i_len_val(len), .i_smp_wr(smp_wr),
        .i_smp_idx(idx), .i_smp_val(sval), .i_manual(man),
        .i_bus_rate(idx[1:0]), .i_uart_pol(down), .i_pwm_period(idle),
        .i_pwm_duty(bt), .i_motor_dir(down), .i_motor_en(out_en),
        .i_led_red(bt), .i_led_green(div), .i_led_blue(bt),
        .i_led_intens(div), .o_pattern_out_0(p0), .o_pattern_out_1(p1),
        .o_pattern_out_2(p2), .o_pattern_out_3(p3), .o_pat_len(plen),
        .o_pat_idx(pidx), .o_arb_busy(busy));
    ppg_probe i_ppg_probe (.i_clk(i_clk), .i_pins({p3, p2, p1, p0}),
        .o_word(word), .o_rise0(rises));

    task automatic chk(string n, logic [7:0] e, logic [7:0] g);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wt(int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task automatic trig();
        @(posedge i_clk);
        t_one <= 1'b1;
        @(posedge i_clk);
        t_one <= 1'b0;
        wt(2);
    endtask

    task automatic t_manual();
        @(posedge i_clk);
        man <= 4'h5;
        out_en <= 1'b1;
        wt(2);
        chk("manual", 8'h05, {4'h0, word});
        @(posedge i_clk);
        out_en <= 1'b0;
        wt(2);
        chk("disabled", 8'h00, {4'h0, word});
        @(posedge i_clk);
        out_en <= 1'b1;
        // UART, SPI, I2C, CAN, LIN; UART runs past a full frame
        for (int k = 3; k < 8; k++) begin
            @(posedge i_clk);
            mode <= ppg_mode_t'(k);
            wt(100);
            if (k == 4) begin
                chk("spi lines", 8'h01, {7'h0, ^word[3:1]});
            end else begin
                chk("unused pins", 8'h00, {6'h0, word[3:2]});
            end
        end
        $display("manual and pin map done");
    endtask

    task automatic t_count();
        @(posedge i_clk);
        mode <= PPG_CNT;
        wt(8);
        n0 = word;
        r0 = rises;
        wt(2);
        chk("count up", {4'h0, n0 + 4'h1}, {4'h0, word});
        wt(62);
        chk("pin0 rises", r0 + 8'd16, rises);
        @(posedge i_clk);
        down <= 1'b1;
        wt(4);
        n0 = word;
        wt(2);
        chk("count down", {4'h0, n0 - 4'h1}, {4'h0, word});
        $display("counter done");
    endtask

    task automatic t_arb();
        @(posedge i_clk);
        mode <= PPG_ARB;
        len_wr <= 1'b1;
        len <= 5'h3;
        smp_wr <= 1'b1;
        for (int k = 0; k < 3; k++) begin
            idx <= 4'(k);
            sval <= 4'(k + 1);
            @(posedge i_clk);
            len_wr <= 1'b0;
        end
        smp_wr <= 1'b0;
        wt(1);
        chk("length", 8'h03, {3'h0, plen});
        trig();
        chk("busy", 8'h01, {7'h0, busy});
        for (int k = 0; k < 3; k++) begin
            chk("sample", 8'(k + 1), {4'h0, word});
            chk("index", 8'((k + 1) % 3), {4'h0, pidx});
            wt(2);
        end
        chk("pass end", 8'h00, {4'h0, word});
        chk("idle", 8'h00, {7'h0, busy});
        @(posedge i_clk);
        burst <= 1'b1;
        ncyc <= 32'h2;
        wt(4);
        trig();
        chk("burst first", 8'h01, {4'h0, word});
        wt(7);
        chk("burst gap", 8'h00, {4'h0, word});
        wt(2);
        chk("burst again", 8'h01, {4'h0, word});
        wt(20);
        @(posedge i_clk);
        clr <= 1'b1;
        burst <= 1'b0;
        @(posedge i_clk);
        clr <= 1'b0;
        wt(1);
        chk("cleared len", 8'h01, {3'h0, plen});
        trig();
        chk("cleared value", 8'h00, {4'h0, word});
        chk("busy after clear", 8'h01, {7'h0, busy});
        $display("pattern player done");
    endtask

    task automatic t_pwm();
        @(posedge i_clk);
        mode <= PPG_PWM;
        wt(10);
        r0 = rises;
        wt(30);
        chk("pwm rises", r0 + 8'd10, rises);
        chk("motor pins", 8'h03, {5'h0, word[3:1]});
        @(posedge i_clk);
        mode <= PPG_LED;
        div <= 32'h0;
        wt(10);
        r0 = rises;
        wt(30);
        chk("red rises", r0 + 8'd10, rises);
        chk("dark pins", 8'h00, {4'h0, word & 4'ha});
        // Runs of four cycles, one idle cycle between them
        @(posedge i_clk);
        mode <= PPG_TEST;
        cont <= 1'b1;
        wt(3);
        chk("cont busy", 8'h01, {7'h0, busy});
        wt(3);
        chk("test gap", 8'h00, {4'h0, word});
        wt(1);
        chk("cont again", 8'h01, {7'h0, busy});
        @(posedge i_clk);
        cont <= 1'b0;
        wt(10);
        chk("cont stop", 8'h00, {7'h0, busy});
        $display("pwm family done");
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial begin
        repeat (6) @(posedge i_clk);
        i_rst_b <= 1'b1;
        t_manual();
        t_count();
        t_arb();
        t_pwm();
        give_verdict();
    end
    // Hang guard
    initial begin
        #200000;
        fail_count++;
        give_verdict();
    end
endmodule

// file: tb/ppg_probe.sv
`timescale 1ns/1ps
module ppg_probe (
    // Pins
    input  wire logic       i_clk,
    input  wire logic [3:0] i_pins,
    // Observed
    output logic      [3:0] o_word,
    output logic      [7:0] o_rise0
);
    // ----------------------------------------
    // Scope probe on the four pins
    // ----------------------------------------
    logic p0_r = 1'b0;
    initial o_rise0 = 8'h00;
    assign o_word = i_pins;
    // Rise count, to measure pin 0 rate
    always @(posedge i_clk) begin
        p0_r <= i_pins[0];
        if (i_pins[0] && !p0_r) begin
            o_rise0 <= o_rise0 + 8'h01;
        end
    end
endmodule
